//--- logic/ptm_pkg.sv
package ptm_pkg;

  // Register byte addresses on the APB.
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CNT_HIGH = 8'h04;
  localparam logic [7:0] OFS_CNT_LOW  = 8'h08;
  localparam logic [7:0] OFS_MOD_HIGH = 8'h0C;
  localparam logic [7:0] OFS_MOD_LOW  = 8'h10;

  // Status and control field positions.
  localparam int BIT_FLAG  = 7;
  localparam int BIT_IEN   = 6;
  localparam int BIT_HALT  = 5;
  localparam int BIT_CLEAR = 4;
  localparam int PS_LSB    = 0;
  localparam int PS_W      = 3;

  // Reset values.
  localparam logic [7:0]  STATUS_RST = 8'h20;
  localparam logic [15:0] MOD_RST    = 16'hFFFF;
  localparam logic [15:0] CNT_RST    = 16'h0000;

  // Prescaler: highest useful code and divider width.
  localparam logic [2:0] PS_MAX  = 3'h6;
  localparam int         PRESC_W = 6;

  // System mode inputs that travel together.
  typedef struct packed {
    logic wait_mode;          // Core is in wait mode.
    logic stop_mode;          // Core is in stop mode.
    logic brk;                // Break interrupt is active.
    logic break_clear_enable; // Break may clear status bits.
  } ptm_sys_t;

  // Whole state of the timer.
  typedef struct packed {
    logic                 overflow_flag;
    logic                 overflow_irq_enable;
    logic                 counter_halt;
    logic [2:0]           prescale_select;
    logic                 inhibit;   // Modulo high written, low pending.
    logic                 armed;     // First clearing step seen.
    logic [15:0]          count;
    logic [PRESC_W-1:0]   presc;
    logic [15:0]          modulo;
    logic                 lat_vld;   // Low byte is captured.
    logic [7:0]           lat;       // Captured low byte.
    logic [7:0]           pend;      // Low byte seen at high setup.
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 irq;
  } ptm_state_t;

endpackage : ptm_pkg

//--- logic/ptm_timer.sv
`timescale 1ns/100ps
// Periodic timer with APB register access.
module ptm_timer #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System mode inputs.
  input  wire ptm_pkg::ptm_sys_t sys_mode,
  // Interrupt request, a level.
  output logic                   irq
);

  // Prescaler width, local so that size casts can name it.
  localparam int PW = ptm_pkg::PRESC_W;

  // Registered state and its next value.
  ptm_pkg::ptm_state_t s_r;
  ptm_pkg::ptm_state_t s_nxt;

  // Bus phase decode.
  logic        setup;      // First cycle of a transfer.
  logic        done;       // Completing edge of a transfer.
  logic        ok;         // Completing transfer that was not refused.
  logic [7:0]  addr8;      // Address cut to the decoded width.
  logic        mapped;     // Address hits a register.
  logic        stat_open;  // Status bits may change now.
  logic        run;        // Counter may advance this cycle.
  logic        tick;       // Counter advances this cycle.
  logic [15:0] cnt_inc;    // Value the counter moves to on a tick.
  logic        ovf;        // Overflow that sets the flag.
  logic        clr_req;    // Counter-clear written this cycle.
  logic        flag_clr;   // Completed two-step clear.
  logic [PW-1:0] mask;     // Prescaler bits that must fill for a tick.

  assign addr8  = paddr[7:0];
  assign setup  = psel && !penable;
  assign done   = psel && penable && s_r.pready;
  assign ok     = done && !s_r.pslverr;
  assign mapped = (addr8 == ptm_pkg::OFS_STATUS)   ||
                  (addr8 == ptm_pkg::OFS_CNT_HIGH) ||
                  (addr8 == ptm_pkg::OFS_CNT_LOW)  ||
                  (addr8 == ptm_pkg::OFS_MOD_HIGH) ||
                  (addr8 == ptm_pkg::OFS_MOD_LOW);

  // Status bits are frozen during break unless software allowed clears.
  assign stat_open = !sys_mode.brk || sys_mode.break_clear_enable;

  // Stop, break and halt all freeze the count; wait does not.
  assign run = !s_r.counter_halt && !sys_mode.stop_mode
               && !sys_mode.brk;

  // Divider mask; code 7 is folded onto divide by 64.
  always_comb
  begin
    logic [2:0] code;
    code = (s_r.prescale_select > ptm_pkg::PS_MAX) ?
           ptm_pkg::PS_MAX : s_r.prescale_select;
    mask = PW'((7'h01 << code) - 7'h01);
  end

  // The prescaler counts every bus clock while run is high; a tick is when its low bits fill.
  assign tick    = run && ((s_r.presc & mask) == mask);
  // Reaching the modulo value wraps to zero on the following tick.
  assign cnt_inc = (s_r.count == s_r.modulo) ? 16'h0000 :
                   16'(s_r.count + 16'h0001);
  assign ovf     = tick && (cnt_inc == s_r.modulo) &&
                   !s_r.inhibit;

  assign clr_req = ok && pwrite && (addr8 == ptm_pkg::OFS_STATUS) &&
                   pwdata[ptm_pkg::BIT_CLEAR];

  // Zero write after an armed read; a write of one never clears.
  assign flag_clr = ok && pwrite && (addr8 == ptm_pkg::OFS_STATUS) &&
                    stat_open && s_r.armed &&
                    !pwdata[ptm_pkg::BIT_FLAG];

  // Next-state logic for the whole block.
  always_comb
  begin
    s_nxt = s_r;

    // Setup cycle: pick the answer now so outputs come from flops.
    s_nxt.pready  = setup;
    if (setup)
    begin
      // Wait mode makes every register unreachable.
      s_nxt.pslverr = !mapped || sys_mode.wait_mode;
      s_nxt.prdata  = 32'h0000_0000;
      if (!pwrite && mapped && !sys_mode.wait_mode)
      begin
        case (addr8)
          ptm_pkg::OFS_STATUS:
          begin
            // Clear bit is write-only and reads as zero.
            s_nxt.prdata[ptm_pkg::BIT_FLAG] = s_r.overflow_flag;
            s_nxt.prdata[ptm_pkg::BIT_IEN]  = s_r.overflow_irq_enable;
            s_nxt.prdata[ptm_pkg::BIT_HALT] = s_r.counter_halt;
            s_nxt.prdata[ptm_pkg::PS_LSB +: ptm_pkg::PS_W] =
              s_r.prescale_select;
          end
          ptm_pkg::OFS_CNT_HIGH:
            s_nxt.prdata[7:0] = s_r.count[15:8];
          ptm_pkg::OFS_CNT_LOW:
            // A captured low byte wins over the live count.
            s_nxt.prdata[7:0] = s_r.lat_vld ? s_r.lat :
                                s_r.count[7:0];
          ptm_pkg::OFS_MOD_HIGH:
            s_nxt.prdata[7:0] = s_r.modulo[15:8];
          ptm_pkg::OFS_MOD_LOW:
            s_nxt.prdata[7:0] = s_r.modulo[7:0];
          default:
            s_nxt.prdata = 32'h0000_0000;
        endcase
      end
      // Low byte of the same instant as the high byte being read.
      s_nxt.pend = s_r.count[7:0];
    end
    else if (done)
    begin
      s_nxt.pslverr = 1'b0;
    end

    // Counting and prescaler.
    if (run)
    begin
      s_nxt.presc = PW'(s_r.presc + 1'b1);
    end
    if (tick)
    begin
      s_nxt.count = cnt_inc;
    end

    // Completed, accepted register accesses.
    if (ok && !pwrite)
    begin
      case (addr8)
        ptm_pkg::OFS_STATUS:
          // First clearing step: the flag was seen set.
          if (stat_open && s_r.prdata[ptm_pkg::BIT_FLAG])
          begin
            s_nxt.armed = 1'b1;
          end
        ptm_pkg::OFS_CNT_HIGH:
          // Later high reads leave an existing capture alone.
          if (!s_r.lat_vld)
          begin
            s_nxt.lat_vld = 1'b1;
            s_nxt.lat     = s_r.pend;
          end
        ptm_pkg::OFS_CNT_LOW:
          s_nxt.lat_vld = 1'b0;
        default:
          s_nxt.lat_vld = s_r.lat_vld;
      endcase
    end
    if (ok && pwrite)
    begin
      case (addr8)
        ptm_pkg::OFS_STATUS:
        begin
          s_nxt.overflow_irq_enable = pwdata[ptm_pkg::BIT_IEN];
          s_nxt.counter_halt        = pwdata[ptm_pkg::BIT_HALT];
          s_nxt.prescale_select     =
            pwdata[ptm_pkg::PS_LSB +: ptm_pkg::PS_W];
          // A protected break write leaves a pending clear armed.
          if (stat_open)
          begin
            s_nxt.armed = 1'b0;
          end
        end
        ptm_pkg::OFS_MOD_HIGH:
        begin
          s_nxt.modulo[15:8] = pwdata[7:0];
          s_nxt.inhibit      = 1'b1;
        end
        ptm_pkg::OFS_MOD_LOW:
        begin
          s_nxt.modulo[7:0] = pwdata[7:0];
          s_nxt.inhibit     = 1'b0;
        end
        default:
          s_nxt.inhibit = s_r.inhibit;
      endcase
    end

    // Counter clear beats counting; halt from the same write keeps zero.
    if (clr_req)
    begin
      s_nxt.count   = ptm_pkg::CNT_RST;
      s_nxt.presc   = '0;
      s_nxt.lat_vld = 1'b0;
      s_nxt.lat     = 8'h00;
    end

    // A fresh overflow wins over any clear and disarms the sequence.
    if (ovf)
    begin
      s_nxt.overflow_flag = 1'b1;
      s_nxt.armed         = 1'b0;
    end
    else if (flag_clr)
    begin
      s_nxt.overflow_flag = 1'b0;
    end

    // Level request, also the wake-up source in wait mode.
    s_nxt.irq = s_nxt.overflow_flag &&
                s_nxt.overflow_irq_enable;
  end

  // State register; reset halts the counter and fills the modulo.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r                     <= '0;
      s_r.counter_halt        <=
        ptm_pkg::STATUS_RST[ptm_pkg::BIT_HALT];
      s_r.overflow_flag       <= 1'b0;
      s_r.overflow_irq_enable <= 1'b0;
      s_r.count               <= ptm_pkg::CNT_RST;
      s_r.modulo              <= ptm_pkg::MOD_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops.
  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq     = s_r.irq;

  // A completed zero write to the status register.
  sequence s_zero_write;
    ok && pwrite && (addr8 == ptm_pkg::OFS_STATUS) &&
    !pwdata[ptm_pkg::BIT_FLAG];
  endsequence

  // A status read that saw the flag set, while bits may change.
  sequence s_flag_seen;
    ok && !pwrite && (addr8 == ptm_pkg::OFS_STATUS) &&
    s_r.prdata[ptm_pkg::BIT_FLAG] && stat_open;
  endsequence

  // Halt stops the count unless a clear is written.
  property p_halt_holds;
    @(posedge pclk) disable iff (!presetn)
    (s_r.counter_halt && !clr_req) |=> $stable(s_r.count);
  endproperty
  a_halt_holds: assert property (p_halt_holds)
    else $error("Counter moved while halted.");

  // Break freezes the count for as long as it lasts.
  property p_break_holds;
    @(posedge pclk) disable iff (!presetn)
    (sys_mode.brk && !clr_req) |=> $stable(s_r.count);
  endproperty
  a_break_holds: assert property (p_break_holds)
    else $error("Counter moved during break.");

  // Stop mode keeps count and prescaler.
  property p_stop_holds;
    @(posedge pclk) disable iff (!presetn)
    (sys_mode.stop_mode && !clr_req) |=>
      ($stable(s_r.count) && $stable(s_r.presc));
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("Timer ran in stop mode.");

  // Clear leaves counter and prescaler at zero; with halt, for two cycles.
  property p_clear_zero;
    @(posedge pclk) disable iff (!presetn)
    (clr_req && pwdata[ptm_pkg::BIT_HALT]) |=>
      (s_r.count == 16'h0000 && s_r.presc == '0) [*2];
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("Clear with halt did not hold zero.");

  // Flag only falls after a seen read followed by a zero write.
  property p_clear_sequence;
    @(posedge pclk) disable iff (!presetn)
    $fell(s_r.overflow_flag) |->
      ($past(s_r.armed) && $past(flag_clr));
  endproperty
  a_clear_sequence: assert property (p_clear_sequence)
    else $error("Flag cleared without the two steps.");

  // An overflow always leaves the flag set, whatever is written.
  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    ovf |=> s_r.overflow_flag && !s_r.armed;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Overflow lost against a clear.");

  // An armed zero write clears the flag when no overflow comes with it.
  property p_two_step;
    @(posedge pclk) disable iff (!presetn)
    (s_r.armed && stat_open && !ovf) ##0 s_zero_write |=>
      !s_r.overflow_flag;
  endproperty
  a_two_step: assert property (p_two_step)
    else $error("Armed zero write left the flag set.");

  // A status read that saw the flag arms the clear, unless overflow hit.
  property p_arm;
    @(posedge pclk) disable iff (!presetn)
    (s_flag_seen ##0 !ovf) |=> s_r.armed;
  endproperty
  a_arm: assert property (p_arm)
    else $error("Status read with flag set did not arm the clear.");

  // Protected break never drops the flag.
  property p_break_protect;
    @(posedge pclk) disable iff (!presetn)
    (sys_mode.brk && !sys_mode.break_clear_enable) |=>
      !$fell(s_r.overflow_flag);
  endproperty
  a_break_protect: assert property (p_break_protect)
    else $error("Flag cleared in protected break.");

  // Inhibited flag cannot rise until the low modulo byte is written.
  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
    s_r.inhibit |=> !$rose(s_r.overflow_flag);
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("Flag set while modulo write pending.");

  // Interrupt is the level of flag and enable, one flop behind next state.
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
    s_r.irq == (s_r.overflow_flag && s_r.overflow_irq_enable);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt level disagrees with flag and enable.");

  // Wait mode refuses register access with an error.
  property p_wait_refuse;
    @(posedge pclk) disable iff (!presetn)
    (setup && sys_mode.wait_mode) |=> (pready && pslverr);
  endproperty
  a_wait_refuse: assert property (p_wait_refuse)
    else $error("Register reached in wait mode.");

  // A captured low byte is what a low read returns.
  property p_latched_low;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && addr8 == ptm_pkg::OFS_CNT_LOW && s_r.lat_vld &&
     !sys_mode.wait_mode)
    |=> (prdata[7:0] == $past(s_r.lat));
  endproperty
  a_latched_low: assert property (p_latched_low)
    else $error("Low byte read ignored the capture.");

  // Counter never passes the modulo value once below it.
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    (tick && s_r.count == s_r.modulo && !clr_req) |=>
      (s_r.count == 16'h0000);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Counter did not wrap at modulo.");

endmodule : ptm_timer

//--- tb/ptm_timer_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the periodic timer, driven over APB.
module ptm_timer_bench;
  // Expected outcome of one bus transfer, queued by the driver.
  typedef struct {
    logic [31:0] exp;  // Expected read data.
    logic [31:0] msk;  // Bits of read data that are compared.
    int          tol;  // Allowed distance for running counts.
    logic        err;  // Expected error response.
  } ptm_note_t;

  // Short names for the register byte addresses.
  localparam logic [7:0] A_ST = ptm_pkg::OFS_STATUS;
  localparam logic [7:0] A_CH = ptm_pkg::OFS_CNT_HIGH;
  localparam logic [7:0] A_CL = ptm_pkg::OFS_CNT_LOW;
  localparam logic [7:0] A_MH = ptm_pkg::OFS_MOD_HIGH;
  localparam logic [7:0] A_ML = ptm_pkg::OFS_MOD_LOW;

  logic              pclk;        // Bus clock, 50 ns period.
  logic              presetn;     // Active-low reset.
  logic              psel;        // APB select.
  logic              penable;     // APB enable.
  logic              pwrite;      // APB direction.
  logic [7:0]        paddr;       // APB byte address.
  logic [31:0]       pwdata;      // APB write data.
  logic [31:0]       prdata;      // APB read data.
  logic              pready;      // APB ready.
  logic              pslverr;     // APB error.
  logic              irq;         // Interrupt request level.
  ptm_pkg::ptm_sys_t sys_mode;    // Wait, stop and break inputs.
  ptm_note_t         notes[$];    // Outstanding expectations.
  int                fail_count;  // Mismatches seen.
  int                n_compared;  // Comparisons made.
  int                p;           // Prescale code under test.
  int                sh;          // Divider exponent for that code.

  // Device under test.
  ptm_timer dut (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .sys_mode (sys_mode),
    .irq      (irq)
  );

  // Free-running bus clock.
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  // Prints the verdict once and ends the run.
  task tally_and_finish;
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Compares one completed transfer against its note.
  task automatic cmp_apb(input ptm_note_t nt, input logic [31:0] rv,
                         input logic er);
    logic ok;
    int   d;
    n_compared++;
    ok = ((rv & nt.msk) === (nt.exp & nt.msk)) && (er === nt.err);
    // Running counts land within a count or two of the estimate.
    if (!ok && nt.tol > 0 && er === nt.err && !$isunknown(rv))
    begin
      d  = int'(rv & nt.msk) - int'(nt.exp);
      ok = (d <= nt.tol) && (d >= -nt.tol);
    end
    if (!ok)
    begin
      fail_count++;
      $display("FAIL apb data/err expected %h/%b seen %h/%b",
               nt.exp, nt.err, rv, er);
    end
  endtask : cmp_apb

  // Watches completing transfers and checks the oldest note.
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      if (notes.size() == 0)
      begin
        fail_count++;
        $display("FAIL apb transfer expected none seen one");
      end
      else
        cmp_apb(notes.pop_front(), prdata, pslverr);
    end

  // One APB transfer; the request is held until pready is sampled.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     input logic [31:0] e, input logic [31:0] m,
                     input int tol, input logic er);
    logic [31:0] rnd;
    int          t;
    rnd = $urandom();
    notes.push_back('{e, m, tol, er});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {rnd[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (t >= 20)
    begin
      fail_count++;
      $display("FAIL pready expected 1 seen %b", pready);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write; writes return zero data and no error.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 32'hFFFF_FFFF, 0, 1'b0);
  endtask : wr

  // Register read with optional mask and tolerance on the low byte.
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hFF, input int tol = 0);
    apb(1'b0, a, 8'h00, {24'h00_0000, e}, {24'hFF_FFFF, m}, tol, 1'b0);
  endtask : rd

  // Waits a little, then up to n cycles, for the interrupt level.
  task automatic irq_is(input logic e, input int n);
    int t;
    t = 0;
    repeat (2) @(negedge pclk);
    while (irq !== e && t < n)
    begin
      @(negedge pclk);
      t++;
    end
    n_compared++;
    if (irq !== e)
    begin
      fail_count++;
      $display("FAIL irq expected %b seen %b", e, irq);
    end
  endtask : irq_is

  // Watchdog: the tests need well under ten thousand cycles.
  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(24));
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    sys_mode = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_ST, 8'h20);  // Reset state.
    rd(A_CH, 8'h00);  // Count high is zero.
    rd(A_CL, 8'h00);  // Count low is zero.
    rd(A_MH, 8'hFF);  // Modulo high is all ones.
    rd(A_ML, 8'hFF);  // Modulo low is all ones.
    apb(1'b0, 8'h14, 8'h00, 32'h0, 32'hFFFF_FFFF, 0, 1'b1);  // Unmapped.
    // Every prescale code: count over a fixed 224-cycle run.
    for (p = 0; p < 8; p++)
    begin
      sh = (p > 6) ? 6 : p;
      wr(A_ST, 8'(8'h30 | p));  // Halt and clear together.
      rd(A_ST, 8'(8'h20 | p));  // Clear bit reads zero.
      rd(A_CL, 8'h00);  // Counter left at zero.
      wr(A_ST, 8'(p));
      repeat (221) @(posedge pclk);
      wr(A_ST, 8'(8'h20 | p));
      rd(A_CH, 8'h00);
      rd(A_CL, 8'(224 >> sh), 8'hFF, 2);  // Rate follows the code.
    end
    // Halted at 3 with divide by 64; capture, run on, read back.
    rd(A_CH, 8'h00);  // Captures the low byte.
    wr(A_ST, 8'h07);
    repeat (221) @(posedge pclk);
    wr(A_ST, 8'h27);  // Halting keeps the count.
    rd(A_CH, 8'h00);  // Second high read keeps the capture.
    rd(A_CL, 8'h03);  // Low read returns the old capture.
    rd(A_CL, 8'h07, 8'hFF, 1);  // Counting went on undisturbed.
    // Stop, then break, freeze a running counter until released.
    for (p = 0; p < 2; p++)
    begin
      if (p == 0)
        sys_mode.stop_mode <= 1'b1;
      else
        sys_mode.brk <= 1'b1;
      wr(A_ST, 8'h30);
      wr(A_ST, 8'h00);
      repeat (50) @(posedge pclk);
      rd(A_CH, 8'h00);  // High read captures the low byte before release.
      rd(A_CL, 8'h00);  // Frozen while the mode holds.
      sys_mode <= '0;
      repeat (50) @(posedge pclk);
      wr(A_ST, 8'h20);
      rd(A_CL, 8'd53, 8'hFF, 2);  // Resumes afterwards.
    end
    // Modulo zero overflows on every tick.
    wr(A_ST, 8'h30);  // Clear and halt before modulo writes.
    wr(A_MH, 8'h00);
    wr(A_ML, 8'h00);
    wr(A_ST, 8'h00);
    irq_is(1'b0, 1);  // Flag without enable raises nothing.
    wr(A_ST, 8'h20);  // Zero write without a prior read.
    rd(A_ST, 8'hA0);  // Flag set and still set.
    wr(A_ST, 8'hE0);  // Enable with a one written to the flag.
    irq_is(1'b1, 4);  // Flag and enable give the level.
    rd(A_ST, 8'hE0);
    wr(A_ST, 8'h60);  // Read then zero write clears.
    irq_is(1'b0, 4);  // Level drops with the flag.
    wr(A_ST, 8'hE0);  // A one alone does not set it.
    rd(A_ST, 8'h60);  // Still clear.
    wr(A_ST, 8'h40);  // Run with enable.
    rd(A_ST, 8'hC0);
    wr(A_ST, 8'h40);  // An overflow lands before this write.
    rd(A_ST, 8'hC0);  // So the flag stays.
    // First clearing step before break, second after it.
    wr(A_ST, 8'hE0);
    rd(A_ST, 8'hE0);
    sys_mode.brk <= 1'b1;
    wr(A_ST, 8'h60);
    rd(A_ST, 8'hE0);  // Protected during break.
    sys_mode.brk <= 1'b0;
    wr(A_ST, 8'h60);
    rd(A_ST, 8'h60);  // Second step completes afterwards.
    // With the break clear enable, clearing in break sticks.
    wr(A_ST, 8'h40);
    wr(A_ST, 8'hE0);
    sys_mode <= 4'b0011;
    rd(A_ST, 8'hE0);
    wr(A_ST, 8'h60);
    sys_mode <= '0;
    rd(A_ST, 8'h60);  // Cleared and stays cleared.
    // Modulo high write blocks the flag until the low write.
    wr(A_ST, 8'h30);
    wr(A_MH, 8'h00);
    wr(A_ST, 8'h00);
    repeat (10) @(posedge pclk);
    rd(A_ST, 8'h00);  // Blocked.
    wr(A_ML, 8'h00);
    rd(A_ST, 8'h80);  // Released by the low write.
    // Wait mode: refused accesses, counting goes on, wakes by irq.
    wr(A_ML, 8'h40);
    wr(A_ST, 8'h30);
    rd(A_ST, 8'hA0);
    wr(A_ST, 8'h20);
    wr(A_ST, 8'h50);  // Left running, not halted, before wait.
    sys_mode.wait_mode <= 1'b1;
    apb(1'b0, A_ST, 8'h00, 32'h0, 32'hFFFF_FFFF, 0, 1'b1);
    irq_is(1'b1, 200);  // Overflow still requests.
    sys_mode.wait_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    tally_and_finish();
  end
endmodule : ptm_timer_bench
